// [verilog/gdm_pkg.sv]
// shared constants, types and register map of the gpio drive-mode block
package gdm_pkg;

  localparam int GDM_PORTS = 5;
  localparam int GDM_PINS = 8;
  localparam int GDM_P4 = 4;
  localparam int GDM_P4_PINS = 4;

  // register indices; byte address is four times the index
  localparam logic [7:0] GDM_IDX_LO [GDM_PORTS] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10};
  localparam logic [7:0] GDM_IDX_HI [GDM_PORTS] = '{8'h01, 8'h05, 8'h09, 8'h0d, 8'h11};
  localparam logic [7:0] GDM_IDX_OVR = 8'hd1;
  localparam int GDM_IDX_LSB = 2;
  localparam int GDM_IDX_MSB = 9;

  localparam logic [7:0] GDM_LO_RST = 8'h00;
  localparam logic [7:0] GDM_HI_RST = 8'hff;
  localparam logic [7:0] GDM_OVR_RST = 8'h00;
  localparam logic [31:0] GDM_RDATA_RST = 32'h0000_0000;

  // override register fields
  localparam int GDM_OVR_P7_SEL = 7;
  localparam int GDM_OVR_P7_EN = 6;
  localparam int GDM_OVR_P4_SEL = 5;
  localparam int GDM_OVR_P4_EN = 4;
  localparam int GDM_OVR_PIN7 = 7;
  localparam int GDM_OVR_PIN4 = 4;

  localparam logic [1:0] GDM_HTRANS_NONSEQ_BIT = 2'h2;
  localparam logic GDM_HRESP_OKAY = 1'b0;

  typedef enum logic [1:0] {
    GDM_MODE_RESISTIVE = 2'b00,
    GDM_MODE_STRONG = 2'b01,
    GDM_MODE_HIGHZ = 2'b10,
    GDM_MODE_OPEN_DRAIN = 2'b11
  } gdm_mode_e;

  typedef enum logic [1:0] {
    GDM_BUS_IDLE = 2'b00,
    GDM_BUS_WRITE = 2'b01,
    GDM_BUS_READ_WAIT = 2'b10,
    GDM_BUS_READ_DONE = 2'b11
  } gdm_bus_e;

  // pad controls of one port, bit n is pin n
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] pull_up;
    logic [7:0] in_en;
  } gdm_pad_s;

  // what the rest of the chip wants on one port
  typedef struct packed {
    logic [7:0] data;
    logic [7:0] func_en;
    logic [7:0] func_val;
  } gdm_port_in_s;

  // internal signals that may be routed onto port 0, with sense_clk_select and sleep steering them
  typedef struct packed {
    logic main_system_clock;
    logic sense_out;
    logic sense_clk;
    logic sense_clk_select;
    logic timer_output;
    logic slow_32k_clock;
    logic sleep;
  } gdm_ovr_src_s;

endpackage : gdm_pkg

// [verilog/gdm_pin_drv.sv]
// per-pin driver decode and input synchroniser for one port
`timescale 1ns/1ns
`default_nettype none
module gdm_pin_drv (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] mode_hi,
  input wire logic [7:0] mode_lo,
  input wire logic [7:0] data,
  input wire logic [7:0] pad_in,
  output gdm_pkg::gdm_pad_s pad,
  output logic [7:0] pin_val
);
  import gdm_pkg::*;

  logic [7:0] sync1;
  logic [7:0] sync2;

  genvar n;
  generate
    for (n = 0; n < GDM_PINS; n++) begin : g_pin
      gdm_mode_e mode;
      assign mode = gdm_mode_e'({mode_hi[n], mode_lo[n]});
      always_comb begin
        pad.out[n] = 1'b0;
        pad.oe[n] = 1'b0;
        pad.pull_up[n] = 1'b0;
        pad.in_en[n] = 1'b1;
        case (mode)
          GDM_MODE_RESISTIVE: begin
            pad.oe[n] = ~data[n];
            pad.pull_up[n] = data[n];
          end
          GDM_MODE_STRONG: begin
            pad.out[n] = data[n];
            pad.oe[n] = 1'b1;
          end
          GDM_MODE_HIGHZ: begin
            pad.in_en[n] = 1'b0;
          end
          GDM_MODE_OPEN_DRAIN: begin
            pad.oe[n] = ~data[n];
          end
          default: begin
            pad.in_en[n] = 1'b0;
          end
        endcase
      end
    end
  endgenerate

  // pads are asynchronous to clk, two flops before any use
  always_ff @(posedge clk) begin
    if (!nrst) begin
      sync1 <= 8'h00;
      sync2 <= 8'h00;
    end else begin
      sync1 <= pad_in;
      sync2 <= sync1;
    end
  end

  // disabled inputs read zero so a floating pad costs nothing downstream
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pin_val <= 8'h00;
    end else begin
      pin_val <= sync2 & pad.in_en;
    end
  end

endmodule : gdm_pin_drv
`default_nettype wire

// [verilog/gdm_drive_ctl.sv]
// gpio drive-mode registers, port 0 output override and ahb-lite slave
// What this block does
// - pin drive setting is high-register bit over low-register bit, same position
// - mode 00 resistive high strong low; mode 01 strong both ways
// - mode 10 high-z, input off; reset gives low zeros, high ones
// - mode 11 open drain: float high, strong low
// - port 4 reads return last bus value in the upper nibble
// - pin 7 select: zero main clock, one sensing output or clock
// - pin 7 enable routes selected signal to port 0 pin 7
// - pin 4 select: zero timer output, one 32 kHz clock
// - pin 4 enable routes selected signal to port 0 pin 4
// - sleep blocks timer and 32 kHz overrides from pin 4
// - enabled override beats any other internal function on the pin
//
// Added by the designer: the AHB-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
module gdm_drive_ctl (
  input wire logic clk,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire gdm_pkg::gdm_port_in_s [gdm_pkg::GDM_PORTS-1:0] port_ctl,
  input wire gdm_pkg::gdm_ovr_src_s ovr_src,
  input wire logic [gdm_pkg::GDM_PORTS-1:0][7:0] pad_in,
  output gdm_pkg::gdm_pad_s [gdm_pkg::GDM_PORTS-1:0] pad,
  output logic [gdm_pkg::GDM_PORTS-1:0][7:0] pin_val
);
  import gdm_pkg::*;

  gdm_bus_e state;
  gdm_bus_e next_state;
  logic [7:0] idx;
  logic addr_ok;
  logic addr_phase;
  logic wr_en;
  logic [7:0] next_rdata;
  logic [7:0] last_bus;
  logic [7:0] dm_lo [GDM_PORTS];
  logic [7:0] dm_hi [GDM_PORTS];
  logic [7:0] ovr;
  logic slow_32k_clock_s1;
  logic slow_32k_clock_s2;
  logic p7_src;
  logic p4_src;
  logic p4_live;
  logic [7:0] p0_ovr_en;
  logic [7:0] p0_ovr_val;
  logic [7:0] eff_data [GDM_PORTS];

  // hsize is accepted as is; only whole-word transfers are expected
  logic unused_hsize;
  assign unused_hsize = ^hsize;

  // bus slave
  assign addr_phase = hsel & hready & htrans[1];
  assign hresp = GDM_HRESP_OKAY;
  // reads take one wait state so a write just before can never be read stale
  assign hreadyout = (state != GDM_BUS_READ_WAIT);
  assign wr_en = (state == GDM_BUS_WRITE) & addr_ok;

  always_comb begin
    next_state = state;
    case (state)
      GDM_BUS_IDLE, GDM_BUS_WRITE, GDM_BUS_READ_DONE: begin
        if (addr_phase) begin
          next_state = hwrite ? GDM_BUS_WRITE : GDM_BUS_READ_WAIT;
        end else begin
          next_state = GDM_BUS_IDLE;
        end
      end
      GDM_BUS_READ_WAIT: begin
        next_state = GDM_BUS_READ_DONE;
      end
      default: begin
        next_state = GDM_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state <= GDM_BUS_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // address capture; anything above the map decodes as unmapped
  always_ff @(posedge clk) begin
    if (!nrst) begin
      idx <= 8'h00;
      addr_ok <= 1'b0;
    end else if (addr_phase) begin
      idx <= haddr[GDM_IDX_MSB:GDM_IDX_LSB];
      addr_ok <= (haddr[31:GDM_IDX_MSB+1] == '0);
    end
  end

  // registers
  genvar p;
  generate
    for (p = 0; p < GDM_PORTS; p++) begin : g_reg
      always_ff @(posedge clk) begin
        if (!nrst) begin
          dm_lo[p] <= GDM_LO_RST;
        end else if (wr_en && idx == GDM_IDX_LO[p]) begin
          dm_lo[p] <= hwdata[7:0];
        end
      end
      always_ff @(posedge clk) begin
        if (!nrst) begin
          dm_hi[p] <= GDM_HI_RST;
        end else if (wr_en && idx == GDM_IDX_HI[p]) begin
          dm_hi[p] <= hwdata[7:0];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ovr <= GDM_OVR_RST;
    end else if (wr_en && idx == GDM_IDX_OVR) begin
      ovr <= hwdata[7:0];
    end
  end

  // last byte seen on the internal data bus, write data or read data
  always_ff @(posedge clk) begin
    if (!nrst) begin
      last_bus <= 8'h00;
    end else if (wr_en) begin
      last_bus <= hwdata[7:0];
    end else if (state == GDM_BUS_READ_WAIT) begin
      last_bus <= next_rdata;
    end
  end

  // read mux; port 4 has only four pins, upper nibble leaks the bus
  always_comb begin
    next_rdata = 8'h00;
    if (addr_ok) begin
      for (int i = 0; i < GDM_PORTS; i++) begin
        if (idx == GDM_IDX_LO[i]) begin
          next_rdata = dm_lo[i];
          if (i == GDM_P4) begin
            next_rdata = {last_bus[7:4], dm_lo[i][3:0]};
          end
        end
        if (idx == GDM_IDX_HI[i]) begin
          next_rdata = dm_hi[i];
          if (i == GDM_P4) begin
            next_rdata = {last_bus[7:4], dm_hi[i][3:0]};
          end
        end
      end
      if (idx == GDM_IDX_OVR) begin
        next_rdata = ovr;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      hrdata <= GDM_RDATA_RST;
    end else if (state == GDM_BUS_READ_WAIT) begin
      hrdata <= {24'h00_0000, next_rdata};
    end
  end

  // overrides
  // the 32 kHz clock comes from its own oscillator
  always_ff @(posedge clk) begin
    if (!nrst) begin
      slow_32k_clock_s1 <= 1'b0;
      slow_32k_clock_s2 <= 1'b0;
    end else begin
      slow_32k_clock_s1 <= ovr_src.slow_32k_clock;
      slow_32k_clock_s2 <= slow_32k_clock_s1;
    end
  end

  // the main clock tap passes through gates only, a flop would halve it
  always_comb begin
    if (ovr[GDM_OVR_P7_SEL]) begin
      p7_src = ovr_src.sense_clk_select ? ovr_src.sense_clk : ovr_src.sense_out;
    end else begin
      p7_src = ovr_src.main_system_clock;
    end
  end

  assign p4_src = ovr[GDM_OVR_P4_SEL] ? slow_32k_clock_s2 : ovr_src.timer_output;
  // in sleep the pin falls back to its normal function
  assign p4_live = ovr[GDM_OVR_P4_EN] & ~ovr_src.sleep;

  always_comb begin
    p0_ovr_en = 8'h00;
    p0_ovr_val = 8'h00;
    p0_ovr_en[GDM_OVR_PIN7] = ovr[GDM_OVR_P7_EN];
    p0_ovr_val[GDM_OVR_PIN7] = ovr[GDM_OVR_P7_EN] & p7_src;
    p0_ovr_en[GDM_OVR_PIN4] = p4_live;
    p0_ovr_val[GDM_OVR_PIN4] = p4_live & p4_src;
  end

  // pin drive
  // override first, then other internal functions, then the data register;
  // the override only shows if software chose an output-capable mode
  generate
    for (p = 0; p < GDM_PORTS; p++) begin : g_port
      logic [7:0] func_data;
      logic [7:0] mode_hi;
      logic [7:0] mode_lo;
      assign func_data = (port_ctl[p].func_en & port_ctl[p].func_val)
                       | (~port_ctl[p].func_en & port_ctl[p].data);
      if (p == 0) begin : g_ovr
        assign eff_data[p] = (p0_ovr_en & p0_ovr_val) | (~p0_ovr_en & func_data);
      end else begin : g_plain
        assign eff_data[p] = func_data;
      end
      if (p == GDM_P4) begin : g_narrow
        // missing pins of port 4 are held high-z with input off
        assign mode_hi = {4'hf, dm_hi[p][GDM_P4_PINS-1:0]};
        assign mode_lo = {4'h0, dm_lo[p][GDM_P4_PINS-1:0]};
      end else begin : g_full
        assign mode_hi = dm_hi[p];
        assign mode_lo = dm_lo[p];
      end
      gdm_pin_drv u_drv (
        .clk(clk),
        .nrst(nrst),
        .mode_hi(mode_hi),
        .mode_lo(mode_lo),
        .data(eff_data[p]),
        .pad_in(pad_in[p]),
        .pad(pad[p]),
        .pin_val(pin_val[p])
      );
    end
  endgenerate

endmodule : gdm_drive_ctl
`default_nettype wire

// [test/gdm_drive_ctl_chk.sv]
// port-level assertions for the gpio drive-mode block
`timescale 1ns/1ns
`default_nettype none
module gdm_drive_ctl_chk (
  input wire logic clk,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire gdm_pkg::gdm_port_in_s [gdm_pkg::GDM_PORTS-1:0] port_ctl,
  input wire gdm_pkg::gdm_ovr_src_s ovr_src,
  input wire logic [gdm_pkg::GDM_PORTS-1:0][7:0] pad_in,
  input wire gdm_pkg::gdm_pad_s [gdm_pkg::GDM_PORTS-1:0] pad,
  input wire logic [gdm_pkg::GDM_PORTS-1:0][7:0] pin_val
);
  import gdm_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_okay;
    hresp == GDM_HRESP_OKAY;
  endproperty
  a_okay: assert property (p_okay)
    else $error("response not okay");
  property p_rd_wait;
    hsel && hready && htrans[1] && !hwrite |=> !hreadyout ##1 hreadyout;
  endproperty
  a_rd_wait: assert property (p_rd_wait)
    else $error("read wait state wrong");
  property p_wr_nowait;
    hsel && hready && htrans[1] && hwrite |=> hreadyout;
  endproperty
  a_wr_nowait: assert property (p_wr_nowait)
    else $error("write data phase stalled");
  property p_upper;
    hrdata[31:8] == 24'h0;
  endproperty
  a_upper: assert property (p_upper)
    else $error("read data upper bits set");
  property p_rst;
    $past(!nrst) |-> pad[1].oe == 8'h00 && pad[1].in_en == 8'h00 && pad[1].pull_up == 8'h00;
  endproperty
  a_rst: assert property (p_rst)
    else $error("pads not high-z after reset");
  property p_p4;
    pad[4].oe[7:4] == 4'h0 && pad[4].in_en[7:4] == 4'h0;
  endproperty
  a_p4: assert property (p_p4)
    else $error("absent port 4 pins active");
  property p_pull;
    (pad[2].pull_up & (pad[2].oe | ~pad[2].in_en)) == 8'h00;
  endproperty
  a_pull: assert property (p_pull)
    else $error("pull-up with driver or input off");
  property p_off;
    (pad[3].oe & ~pad[3].in_en) == 8'h00;
  endproperty
  a_off: assert property (p_off)
    else $error("driver on in high-z mode");
  property p_gate;
    (pin_val[1] & ~$past(pad[1].in_en)) == 8'h00;
  endproperty
  a_gate: assert property (p_gate)
    else $error("input seen while disabled");
  property p_out_data;
    ((pad[1].out | pad[1].pull_up) & ~((port_ctl[1].func_en & port_ctl[1].func_val)
      | (~port_ctl[1].func_en & port_ctl[1].data))) == 8'h00;
  endproperty
  a_out_data: assert property (p_out_data)
    else $error("pin pulled or driven high against its data");
endmodule : gdm_drive_ctl_chk
bind gdm_drive_ctl gdm_drive_ctl_chk u_chk (.clk(clk), .nrst(nrst), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .port_ctl(port_ctl), .ovr_src(ovr_src), .pad_in(pad_in), .pad(pad), .pin_val(pin_val));
`default_nettype wire

// [test/gdm_pad_model.sv]
// external circuitry on the port pins
`timescale 1ns/1ns
`default_nettype none
module gdm_pad_model (
  input wire logic clk,
  input wire gdm_pkg::gdm_pad_s [gdm_pkg::GDM_PORTS-1:0] pad,
  output logic [gdm_pkg::GDM_PORTS-1:0][7:0] pad_in
);
  import gdm_pkg::*;
  // a floating pin toggles so no stale level passes for a real one
  logic [7:0] flt = 8'h55;
  always_ff @(posedge clk) begin
    flt <= ~flt;
  end
  always_comb begin
    for (int i = 0; i < GDM_PORTS; i++) begin
      pad_in[i] = (pad[i].oe & pad[i].out) | (~pad[i].oe & (pad[i].pull_up | flt));
    end
  end
endmodule : gdm_pad_model
`default_nettype wire

// [test/gdm_drive_ctl_tb_top.sv]
// self-checking bench of the gpio drive-mode block
`timescale 1ns/1ns
`default_nettype none
module gdm_drive_ctl_tb_top;
  import gdm_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic [31:0] q;
  gdm_port_in_s [GDM_PORTS-1:0] port_ctl = '0;
  gdm_ovr_src_s ovr_src = '0;
  logic [GDM_PORTS-1:0][7:0] pad_in;
  logic [GDM_PORTS-1:0][7:0] pin_val;
  gdm_pad_s [GDM_PORTS-1:0] pad;
  int n_mismatch = 0;
  int samples_checked = 0;
  logic [7:0] dv [3] = '{8'h00, 8'hff, 8'h96};
  // override value, sources {clk,s_out,s_clk,s_sel,timer,32k,sleep}, pins {7,4}
  logic [7:0] oreg [7] = '{8'h50, 8'h50, 8'hf0, 8'hf0, 8'hf0, 8'h00, 8'h50};
  logic [6:0] osrc [7] = '{7'h44, 7'h3a, 7'h1a, 7'h64, 7'h23, 7'h7e, 7'h05};
  logic [1:0] oexp [7] = '{2'h3, 2'h0, 2'h3, 2'h2, 2'h2, 2'h0, 2'h0};
  always #2 clk = ~clk;
  gdm_drive_ctl u_dut (.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .port_ctl(port_ctl), .ovr_src(ovr_src), .pad_in(pad_in),
    .pad(pad), .pin_val(pin_val));
  gdm_pad_model u_pads (.clk(clk), .pad(pad), .pad_in(pad_in));
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : conclude
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic xfer(input logic w, input logic [31:0] a, input logic [7:0] d);
    hsel <= 1'b1;
    htrans <= GDM_HTRANS_NONSEQ_BIT;
    haddr <= a;
    hwrite <= w;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    q = hrdata;
  endtask : xfer
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    xfer(1'b1, {22'h0, i, 2'h0}, d);
  endtask : wr
  task automatic rd(input logic [7:0] i, input logic [7:0] e, input logic [7:0] m);
    xfer(1'b0, {22'h0, i, 2'h0}, 8'h00);
    chk("register", {24'h0, e & m}, q & {24'h0, m});
  endtask : rd
  function automatic gdm_pad_s ep(input logic [7:0] h, input logic [7:0] l, input logic [7:0] d);
    gdm_pad_s p;
    p.in_en = ~(h & ~l);
    p.pull_up = ~h & ~l & d;
    p.oe = (~h & l) | (~(h ^ l) & ~d);
    p.out = ~h & l & d;
    return p;
  endfunction : ep
  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    for (int p = 0; p < GDM_PORTS; p++) begin
      rd(GDM_IDX_LO[p], GDM_LO_RST, p == GDM_P4 ? 8'h0f : 8'hff);
      rd(GDM_IDX_HI[p], GDM_HI_RST, p == GDM_P4 ? 8'h0f : 8'hff);
      chk("pad", ep(GDM_HI_RST, GDM_LO_RST, 8'h00), pad[p]);
    end
    rd(GDM_IDX_OVR, GDM_OVR_RST, 8'hff);
    for (int p = 0; p < GDM_PORTS; p++) begin
      wr(GDM_IDX_LO[p], 8'h3c ^ p[7:0]);
      rd(GDM_IDX_LO[p], 8'h3c ^ p[7:0], 8'hff);
      wr(GDM_IDX_HI[p], 8'hc3 ^ p[7:0]);
      rd(GDM_IDX_HI[p], 8'hc3 ^ p[7:0], 8'hff);
    end
    wr(GDM_IDX_LO[GDM_P4], 8'h5c);
    wr(GDM_IDX_LO[0], 8'ha5);
    rd(GDM_IDX_LO[GDM_P4], 8'hac, 8'hff);
    xfer(1'b1, 32'h0000_0400, 8'hff);
    xfer(1'b1, 32'h0000_03fc, 8'hff);
    rd(GDM_IDX_LO[0], 8'ha5, 8'hff);
    xfer(1'b0, 32'h0000_03fc, 8'h00);
    chk("unmapped", 32'h0000_0000, q);
    wr(GDM_IDX_HI[1], 8'h0c);
    wr(GDM_IDX_LO[1], 8'h0a);
    foreach (dv[k]) begin
      port_ctl[1].data <= dv[k];
      repeat (4) @(posedge clk);
      chk("pad", ep(8'h0c, 8'h0a, dv[k]), pad[1]);
      chk("pin", {24'h0, dv[k] & 8'hf3}, {24'h0, pin_val[1] & 8'hf7});
    end
    // strong drive first, else pad.out stays low whatever the override
    wr(GDM_IDX_HI[0], 8'h00);
    wr(GDM_IDX_LO[0], 8'hff);
    port_ctl[0] <= {8'h00, 8'hff, 8'h00};
    foreach (oreg[k]) begin
      ovr_src <= osrc[k];
      wr(GDM_IDX_OVR, oreg[k]);
      repeat (3) @(posedge clk);
      chk("override", {30'h0, oexp[k]}, {30'h0, pad[0].out[7], pad[0].out[4]});
    end
    conclude();
  end
  initial begin
    #40000;
    n_mismatch++;
    conclude();
  end
endmodule : gdm_drive_ctl_tb_top
`default_nettype wire
